// ---- logic/adcseq_top.v ----
// Purpose: Conversion sequencer of a successive-approximation converter.
// Assumes: CLK at 50 MHz; AXI4-Lite slave; converter core result on pins.
// Notes:   All top outputs come straight from flip-flops.
//
// The AXI4-Lite register port and the address map are this design's own decisions.
`timescale 1ns/100ps
`include "adcseq_regs.vh"

// How it works
// - Converter clock derived from CPU clock by prescaler.
// - Prescaler runs while enabled, reset when disabled.
// - Single start waits for next converter clock edge.
// - Normal conversion lasts 13 converter clocks.
// - First conversion after enable lasts 25 clocks.
// - Sample-hold at 1.5 normal, 13.5 first.
// - Result written and done flag set together.
// - Start bit clears with result; rewrite relaunches.
// - Trigger event resets the prescaler.
// - Triggered sample-hold two clocks after trigger edge, except in 25-clock conversions (rising edge of cycle 14).
// - Trigger synchronisation adds three CPU clocks.
// - Triggered differential conversions always take 25 clocks.
// - Free running restarts at once, start stays high.
// - Start bit reads one during any conversion.
// - Free running ignores whether done flag cleared.
module adcseq_top #(
  parameter RW = 10
) (
  input  wire          CLK,
  input  wire          RST,
  input  wire [3:0]    S_AXI_AWADDR,
  input  wire          S_AXI_AWVALID,
  output reg           S_AXI_AWREADY,
  input  wire [31:0]   S_AXI_WDATA,
  input  wire [3:0]    S_AXI_WSTRB,
  input  wire          S_AXI_WVALID,
  output reg           S_AXI_WREADY,
  output reg  [1:0]    S_AXI_BRESP,
  output reg           S_AXI_BVALID,
  input  wire          S_AXI_BREADY,
  input  wire [3:0]    S_AXI_ARADDR,
  input  wire          S_AXI_ARVALID,
  output reg           S_AXI_ARREADY,
  output reg  [31:0]   S_AXI_RDATA,
  output reg  [1:0]    S_AXI_RRESP,
  output reg           S_AXI_RVALID,
  input  wire          S_AXI_RREADY,
  input  wire          TRIGGER_IN,
  input  wire [RW-1:0] CORE_RESULT,
  output reg           SAMPLE_HOLD,
  output reg           CONV_ACTIVE,
  output reg           IRQ
);

  localparam ST_IDLE = 2'd0;
  localparam ST_WAIT = 2'd1;
  localparam ST_CONV = 2'd2;

  // Control, status, mask and data register fields.
  reg [2:0]    div_q;
  reg          ate_q;
  reg [1:0]    tsrc_q;
  reg          diff_q;
  reg          start_q;
  reg          en_q;
  reg          done_q;
  reg          mask_q;
  reg [RW-1:0] data_q;

  reg [1:0]    state_q;
  reg [4:0]    cyc_q;
  reg [4:0]    len_q;
  reg [4:0]    sh_q;
  reg          first_q;
  reg          trig_start_q;

  // Trigger pin synchroniser and edge detect.
  reg          trg_s1_q;
  reg          trg_s2_q;
  reg          trg_s3_q;

  // Bus write side latches.
  reg          aw_got_q;
  reg          w_got_q;
  reg [3:0]    aw_addr_q;
  reg [31:0]   w_data_q;
  reg [3:0]    w_strb_q;

  wire         ck_rise;
  wire         ck_fall;
  wire         trig_edge;
  wire         trig_evt;
  wire         wr_go;
  wire         wr_ctrl;
  wire         sw_start;
  wire         finish;

  function addr_hit;
    input [3:0] a;
    input [3:0] off;
    begin
      addr_hit = (a == off);
    end
  endfunction

  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      trg_s1_q <= 1'b0;
      trg_s2_q <= 1'b0;
      trg_s3_q <= 1'b0;
    end else begin
      trg_s1_q <= TRIGGER_IN;
      trg_s2_q <= trg_s1_q;
      trg_s3_q <= trg_s2_q;
    end
  end

  // Two sync stages plus the edge stage give three CPU clocks of latency.
  assign trig_edge = trg_s2_q & ~trg_s3_q;
  assign trig_evt  = en_q && ate_q && (tsrc_q == `ADCSEQ_TSRC_PIN) &&
                     trig_edge && (state_q == ST_IDLE);

  assign wr_go   = aw_got_q && w_got_q && !S_AXI_BVALID;
  assign wr_ctrl = wr_go && addr_hit(aw_addr_q, `ADCSEQ_OFF_CTRL) &&
                   w_strb_q[0];
  // A start written together with the enable bit counts as a start.
  assign sw_start = wr_ctrl && w_data_q[`ADCSEQ_CTRL_START] &&
                    (w_strb_q[1] ? w_data_q[`ADCSEQ_CTRL_EN] : en_q);
  assign finish = (state_q == ST_CONV) && ck_rise && (cyc_q == len_q);

  adcseq_prescaler u_pre (
    .clk     (CLK),
    .rst     (RST),
    .run     (en_q),
    .restart (trig_evt),
    .div_sel (div_q),
    .rise    (ck_rise),
    .fall    (ck_fall)
  );

  // Bus slave: address and data taken in either order, response after both.
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= `ADCSEQ_RESP_OKAY;
      aw_got_q      <= 1'b0;
      w_got_q       <= 1'b0;
      aw_addr_q     <= 4'h0;
      w_data_q      <= 32'h0;
      w_strb_q      <= 4'h0;
    end else begin
      S_AXI_AWREADY <= !aw_got_q && !S_AXI_AWREADY && !S_AXI_BVALID;
      S_AXI_WREADY  <= !w_got_q && !S_AXI_WREADY && !S_AXI_BVALID;
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_got_q  <= 1'b1;
        aw_addr_q <= S_AXI_AWADDR;
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_got_q  <= 1'b1;
        w_data_q <= S_AXI_WDATA;
        w_strb_q <= S_AXI_WSTRB;
        S_AXI_WREADY <= 1'b0;
      end
      if (wr_go) begin
        aw_got_q     <= 1'b0;
        w_got_q      <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= (aw_addr_q[1:0] != 2'b00 ||
                         aw_addr_q == `ADCSEQ_OFF_DATA) ?
                        `ADCSEQ_RESP_SLVERR : `ADCSEQ_RESP_OKAY;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h0;
      S_AXI_RRESP   <= `ADCSEQ_RESP_OKAY;
    end else begin
      S_AXI_ARREADY <= !S_AXI_ARREADY && !S_AXI_RVALID;
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_ARREADY <= 1'b0;
        S_AXI_RVALID  <= 1'b1;
        S_AXI_RRESP   <= `ADCSEQ_RESP_OKAY;
        S_AXI_RDATA   <= 32'h0;
        case (S_AXI_ARADDR)
          `ADCSEQ_OFF_CTRL: begin
            // Start reads one for any conversion in flight.
            S_AXI_RDATA[8:0] <= {en_q, start_q || state_q != ST_IDLE,
                                 diff_q, tsrc_q, ate_q, div_q};
          end
          `ADCSEQ_OFF_STATUS: S_AXI_RDATA[0] <= done_q;
          `ADCSEQ_OFF_MASK:   S_AXI_RDATA[0] <= mask_q;
          `ADCSEQ_OFF_DATA:   S_AXI_RDATA[RW-1:0] <= data_q;
          default:            S_AXI_RRESP <= `ADCSEQ_RESP_SLVERR;
        endcase
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

  // Control, mask and done flag registers.
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      div_q  <= 3'd0;
      ate_q  <= 1'b0;
      tsrc_q <= 2'd0;
      diff_q <= 1'b0;
      en_q   <= 1'b0;
      mask_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        div_q  <= w_data_q[`ADCSEQ_CTRL_DIV_MSB:`ADCSEQ_CTRL_DIV_LSB];
        ate_q  <= w_data_q[`ADCSEQ_CTRL_ATE];
        tsrc_q <= w_data_q[`ADCSEQ_CTRL_TSRC_MSB:`ADCSEQ_CTRL_TSRC_LSB];
        diff_q <= w_data_q[`ADCSEQ_CTRL_DIFF];
      end
      if (wr_go && addr_hit(aw_addr_q, `ADCSEQ_OFF_CTRL) && w_strb_q[1])
        en_q <= w_data_q[`ADCSEQ_CTRL_EN];
      if (wr_go && addr_hit(aw_addr_q, `ADCSEQ_OFF_MASK) && w_strb_q[0])
        mask_q <= w_data_q[0];
      // A completion in the clearing cycle wins over the clear.
      if (finish)
        done_q <= 1'b1;
      else if (wr_go && addr_hit(aw_addr_q, `ADCSEQ_OFF_STATUS) &&
               w_strb_q[0] && w_data_q[`ADCSEQ_ST_DONE])
        done_q <= 1'b0;
    end
  end

  // Conversion sequencer, counting converter clock rising edges.
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_q      <= ST_IDLE;
      start_q      <= 1'b0;
      cyc_q        <= 5'd0;
      len_q        <= `ADCSEQ_CYC_NORMAL;
      sh_q         <= `ADCSEQ_SH_NORMAL;
      first_q      <= 1'b1;
      trig_start_q <= 1'b0;
      data_q       <= {RW{1'b0}};
      SAMPLE_HOLD  <= 1'b0;
      CONV_ACTIVE  <= 1'b0;
      IRQ          <= 1'b0;
    end else begin
      IRQ         <= done_q && mask_q;
      SAMPLE_HOLD <= 1'b0;
      CONV_ACTIVE <= (state_q == ST_CONV);
      if (!en_q) begin
        state_q <= ST_IDLE;
        start_q <= sw_start;
        first_q <= 1'b1;
      end else begin
        if (sw_start)
          start_q <= 1'b1;
        case (state_q)
          ST_IDLE: begin
            if (sw_start || start_q) begin
              state_q      <= ST_WAIT;
              trig_start_q <= 1'b0;
            end else if (trig_evt) begin
              state_q      <= ST_WAIT;
              trig_start_q <= 1'b1;
            end
          end
          ST_WAIT: begin
            if (ck_rise) begin
              state_q <= ST_CONV;
              cyc_q   <= 5'd1;
              if (first_q || (diff_q && ate_q &&
                  tsrc_q != `ADCSEQ_TSRC_FREE)) begin
                len_q <= `ADCSEQ_CYC_FIRST;
                sh_q  <= `ADCSEQ_SH_FIRST;
              end else begin
                len_q <= `ADCSEQ_CYC_NORMAL;
                sh_q  <= trig_start_q ? `ADCSEQ_SH_TRIG - 5'd1 :
                         `ADCSEQ_SH_NORMAL;
              end
            end
          end
          ST_CONV: begin
            // Sample-hold lands on a falling edge for the .5 timing.
            if (ck_fall && cyc_q == sh_q && !trig_start_q)
              SAMPLE_HOLD <= 1'b1;
            if (ck_rise && trig_start_q && cyc_q == sh_q)
              SAMPLE_HOLD <= 1'b1;
            if (ck_rise) begin
              if (cyc_q == len_q) begin
                data_q  <= CORE_RESULT;
                first_q <= 1'b0;
                if (ate_q && tsrc_q == `ADCSEQ_TSRC_FREE) begin
                  // Free running reloads at once, done flag state aside.
                  state_q <= ST_CONV;
                  cyc_q   <= 5'd1;
                  start_q <= 1'b1;
                  len_q   <= `ADCSEQ_CYC_NORMAL;
                  sh_q    <= `ADCSEQ_SH_NORMAL;
                end else begin
                  state_q <= ST_IDLE;
                  start_q <= 1'b0;
                  if (diff_q && ate_q)
                    first_q <= 1'b1;
                end
              end else begin
                cyc_q <= cyc_q + 5'd1;
              end
            end
          end
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end

endmodule

// ---- pkg/adcseq_regs.vh ----
// Purpose: Register offsets, field positions and timing counts of the
//          converter sequencer.
// Assumes: AXI4-Lite, 32-bit data, one aligned word per register.
// Notes:   Definitions only.
`ifndef ADCSEQ_REGS_VH
`define ADCSEQ_REGS_VH

`define ADCSEQ_OFF_CTRL     4'h0
`define ADCSEQ_OFF_STATUS   4'h4
`define ADCSEQ_OFF_MASK     4'h8
`define ADCSEQ_OFF_DATA     4'hc

`define ADCSEQ_CTRL_DIV_LSB 0
`define ADCSEQ_CTRL_DIV_MSB 2
`define ADCSEQ_CTRL_ATE     3
`define ADCSEQ_CTRL_TSRC_LSB 4
`define ADCSEQ_CTRL_TSRC_MSB 5
`define ADCSEQ_CTRL_DIFF    6
`define ADCSEQ_CTRL_START   7
`define ADCSEQ_CTRL_EN      8

`define ADCSEQ_TSRC_FREE    2'h0
`define ADCSEQ_TSRC_PIN     2'h1

`define ADCSEQ_ST_DONE      0

`define ADCSEQ_CYC_NORMAL   5'h0d
`define ADCSEQ_CYC_FIRST    5'h19
// Outside triggered conversions, sample-hold counts name the converter
// cycle, counted from one at the start edge, whose falling edge samples:
// 1.5 is cycle 2, 13.5 cycle 14.
`define ADCSEQ_SH_NORMAL    5'h02
`define ADCSEQ_SH_FIRST     5'h0e
`define ADCSEQ_SH_TRIG      5'h02

`define ADCSEQ_RESP_OKAY    2'h0
`define ADCSEQ_RESP_SLVERR  2'h2

`endif

// ---- logic/adcseq_prescaler.v ----
// Purpose: Power-of-two prescaler giving converter clock edge pulses.
// Assumes: One system clock; the enables are same-domain levels.
// Notes:   Rise and fall pulses mark the converter clock's two edges.
`timescale 1ns/100ps

module adcseq_prescaler #(
  parameter CW = 7
) (
  input  wire         clk,
  input  wire         rst,
  input  wire         run,
  input  wire         restart,
  input  wire [2:0]   div_sel,
  output reg          rise,
  output reg          fall
);

  reg [CW-1:0] cnt_q;
  wire [CW-1:0] half;
  wire [CW-1:0] top;

  // Setting 0 and 1 both divide by two; n otherwise divides by 2**n.
  assign top  = (div_sel < 3'd2) ? {{(CW-1){1'b0}}, 1'b1} :
                ({{(CW-1){1'b0}}, 1'b1} << div_sel) - {{(CW-1){1'b0}}, 1'b1};
  assign half = top >> 1;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= {CW{1'b0}};
      rise  <= 1'b0;
      fall  <= 1'b0;
    end else if (!run || restart) begin
      cnt_q <= {CW{1'b0}};
      rise  <= 1'b0;
      fall  <= 1'b0;
    end else begin
      // A shrinking ratio takes effect without stalling the count.
      cnt_q <= (cnt_q >= top) ? {CW{1'b0}} : cnt_q + 1'b1;
      rise  <= (cnt_q >= top);
      fall  <= (cnt_q == half);
    end
  end

endmodule

// ---- verification/adcseq_core_model.sv ----
// Purpose: Behavioural converter core for the sequencer bench.
// Assumes: The sample strobe is a one-cycle pulse on clk.
// Notes:   A fresh random result appears after each sample instant.
`timescale 1ns/100ps

module adcseq_core_model (
  input  wire logic  clk,
  input  wire logic  rst,
  input  wire logic  sample,
  output logic [9:0] result
);
  integer seed = 32'ha3dfdf1f;
  integer r;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      result <= 10'h2aa;
    end else if (sample) begin
      r = $random(seed);
      result <= r[9:0];
    end
  end
endmodule

// ---- verification/adcseq_top_asserts.sv ----
// Purpose: Port assertions for the conversion sequencer.
// Assumes: One clock CLK, asynchronous active-high RST.
// Notes:   Bound to adcseq_top below the module.
`timescale 1ns/100ps

module adcseq_top_asserts (
  input wire logic CLK,
  input wire logic RST,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic TRIGGER_IN,
  input wire logic SAMPLE_HOLD,
  input wire logic CONV_ACTIVE
);
  logic [11:0] act_q;
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  // Busy cycle count; it saturates so long free runs cannot wrap.
  always @(posedge CLK or posedge RST) begin
    if (RST) act_q <= 12'h000;
    else if (!CONV_ACTIVE) act_q <= 12'h000;
    else if (act_q != 12'hfff) act_q <= act_q + 12'h001;
  end
  property p_sh_pulse; SAMPLE_HOLD |=> !SAMPLE_HOLD; endproperty
  a_sh_pulse: assert property (p_sh_pulse)
    else $error("strobe too wide");
  property p_sh_busy; SAMPLE_HOLD |-> CONV_ACTIVE; endproperty
  a_sh_busy: assert property (p_sh_busy)
    else $error("strobe while idle");
  property p_sh_late; $rose(CONV_ACTIVE) |-> !SAMPLE_HOLD; endproperty
  a_sh_late: assert property (p_sh_late)
    else $error("strobe at start");
  property p_conv_len; $fell(CONV_ACTIVE) |-> act_q >= 12'h018; endproperty
  a_conv_len: assert property (p_conv_len)
    else $error("conversion too short");
  property p_trig; $rose(TRIGGER_IN) |-> !SAMPLE_HOLD [*3]; endproperty
  a_trig: assert property (p_trig)
    else $error("trigger not synchronised");
  property p_rd_lat; S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID;
  endproperty
  a_rd_lat: assert property (p_rd_lat)
    else $error("late read answer");
  property p_rd_end; S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID;
  endproperty
  a_rd_end: assert property (p_rd_end)
    else $error("read answer repeated");
  property p_wr_end; S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID;
  endproperty
  a_wr_end: assert property (p_wr_end)
    else $error("write answer repeated");
endmodule

bind adcseq_top adcseq_top_asserts chk (
  .CLK           (CLK),
  .RST           (RST),
  .S_AXI_ARVALID (S_AXI_ARVALID),
  .S_AXI_ARREADY (S_AXI_ARREADY),
  .S_AXI_RVALID  (S_AXI_RVALID),
  .S_AXI_RREADY  (S_AXI_RREADY),
  .S_AXI_BVALID  (S_AXI_BVALID),
  .S_AXI_BREADY  (S_AXI_BREADY),
  .TRIGGER_IN    (TRIGGER_IN),
  .SAMPLE_HOLD   (SAMPLE_HOLD),
  .CONV_ACTIVE   (CONV_ACTIVE)
);

// ---- verification/test_adc_conversion_sequencer.sv ----
// Purpose: Self-checking bench for the conversion sequencer.
// Assumes: 50 MHz CLK; AXI4-Lite master tasks; core model partner.
// Notes:   Fast converter clocks keep the run short.
`timescale 1ns/100ps

module test_adc_conversion_sequencer;
  logic CLK = 1'b0, RST = 1'b1, TRIGGER_IN = 1'b0, shd = 1'b0;
  logic [3:0] S_AXI_AWADDR = 4'h0, S_AXI_ARADDR = 4'h0, S_AXI_WSTRB = 4'hf;
  logic [31:0] S_AXI_WDATA = 32'h0, rd;
  logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
  logic S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
  wire S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY;
  wire S_AXI_RVALID, SAMPLE_HOLD, CONV_ACTIVE, IRQ;
  wire [1:0] S_AXI_BRESP, S_AXI_RRESP;
  wire [31:0] S_AXI_RDATA;
  wire [9:0] CORE_RESULT;
  logic [1:0] rr;
  integer fails = 0, num_checks = 0, seed = 32'ha3dfdf1f, d, p, c, i;
  integer q[$];

  adcseq_top DUT (.CLK(CLK), .RST(RST),
    .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID),
    .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA),
    .S_AXI_WSTRB(S_AXI_WSTRB), .S_AXI_WVALID(S_AXI_WVALID),
    .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
    .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
    .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
    .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
    .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID),
    .S_AXI_RREADY(S_AXI_RREADY), .TRIGGER_IN(TRIGGER_IN),
    .CORE_RESULT(CORE_RESULT), .SAMPLE_HOLD(SAMPLE_HOLD),
    .CONV_ACTIVE(CONV_ACTIVE), .IRQ(IRQ));
  adcseq_core_model core (.clk(CLK), .rst(RST), .sample(SAMPLE_HOLD),
    .result(CORE_RESULT));

  initial forever #10 CLK = ~CLK;
  // Queues the core output one cycle after each strobe, once it settled.
  always @(negedge CLK) begin
    if (shd) q.push_back(CORE_RESULT);
    shd = SAMPLE_HOLD;
  end

  task bad(input string m);
    begin
      fails++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task chk(input [31:0] g, input [31:0] e, input string m);
    begin
      num_checks++;
      if (g !== e) bad(m);
    end
  endtask
  task conclude;
    begin
      if (fails == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
    end
  endtask
  // One AXI4-Lite transfer; the answer lands in rd and rr.
  task bus(input w, input [3:0] a, input [31:0] v);
    integer n;
    begin
      @(posedge CLK);
      S_AXI_AWADDR <= a;
      S_AXI_ARADDR <= a;
      S_AXI_WDATA <= v;
      S_AXI_AWVALID <= w;
      S_AXI_WVALID <= w;
      S_AXI_BREADY <= w;
      S_AXI_ARVALID <= !w;
      S_AXI_RREADY <= !w;
      for (n = 0; n < 99; n++) begin
        @(posedge CLK);
        if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
        if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
        if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
        if (w ? S_AXI_BVALID : S_AXI_RVALID) begin
          rr = w ? S_AXI_BRESP : S_AXI_RRESP;
          rd = S_AXI_RDATA;
          S_AXI_BREADY <= 1'b0;
          S_AXI_RREADY <= 1'b0;
          n = 200;
        end
      end
      if (n < 200) begin
        bad("bus hang");
        conclude;
      end
    end
  endtask
  // Waits for the interrupt, counting on from c, then checks the time.
  task wait_irq(input integer lo, input integer hi);
    begin
      while (c < 4000 && IRQ !== 1'b1) begin
        @(posedge CLK);
        c++;
      end
      if (c >= 4000) begin
        bad("no completion");
        conclude;
      end
      chk(c >= lo && c <= hi, 1, "conversion time");
    end
  endtask
  task result;
    begin
      chk(q.size(), 1, "sample count");
      bus(1'b0, 4'hc, 32'h0);
      chk(rd, q.size() ? q[$] : -1, "result");
      q.delete();
      bus(1'b0, 4'h4, 32'h0);
      chk(rd, 1, "done flag");
      bus(1'b1, 4'h4, 32'h1);
      @(posedge CLK);
      chk(IRQ, 0, "irq clear");
    end
  endtask

  initial begin
    repeat (12) @(posedge CLK);
    RST <= 1'b0;
    for (i = 0; i < 16; i += 4) begin
      bus(1'b0, i[3:0], 32'h0);
      chk(rd, 0, "reset value");
    end
    bus(1'b0, 4'h2, 32'h0);
    chk(rr, 2, "misaligned read");
    bus(1'b1, 4'hc, 32'h3ff);
    chk(rr, 2, "result write");
    bus(1'b1, 4'h8, 32'h1);
    for (i = 0; i < 2; i++) begin
      d = $unsigned($random(seed)) % 4;
      p = d < 2 ? 2 : 1 << d;
      // A fast converter clock is used; lower resolution is acceptable.
      bus(1'b1, 4'h0, 32'h180 | d);
      c = 0;
      wait_irq(25 * p - 3, 26 * p + 6);
      bus(1'b1, 4'h8, 32'h0);
      @(posedge CLK);
      chk(IRQ, 0, "masked irq");
      bus(1'b1, 4'h8, 32'h1);
      @(posedge CLK);
      chk(IRQ, 1, "unmasked irq");
      result;
      bus(1'b0, 4'h0, 32'h0);
      chk(rd, 32'h100 | d, "start cleared");
      bus(1'b1, 4'h0, 32'h180 | d);
      bus(1'b0, 4'h0, 32'h0);
      chk(rd[7], 1, "busy bit");
      c = 0;
      wait_irq(13 * p - 12, 14 * p + 6);
      result;
      bus(1'b1, 4'h0, 32'h118 | i << 6 | d);
      TRIGGER_IN <= 1'b1;
      c = 0;
      while (c < 999 && SAMPLE_HOLD !== 1'b1) begin
        @(posedge CLK);
        c++;
      end
      if (c >= 999) begin
        bad("no sample strobe");
        conclude;
      end
      TRIGGER_IN <= 1'b0;
      if (i == 0)
        chk(c>=2*p && c<=2*p+6, 1, "trigger");
      wait_irq(i ? 25 * p : 13 * p, (i ? 27 : 15) * p + 8);
      result;
      bus(1'b1, 4'h0, 32'h188 | d);
      repeat (40 * p) @(posedge CLK);
      chk(q.size() >= 2, 1, "free run");
      bus(1'b0, 4'h0, 32'h0);
      chk(rd[7], 1, "start held");
      bus(1'b1, 4'h4, 32'h1);
      q.delete();
      repeat (30 * p) @(posedge CLK);
      chk(q.size() >= 2, 1, "free run after clear");
      bus(1'b1, 4'h0, 32'h100 | d);
      c = 0;
      while (c < 999 && CONV_ACTIVE !== 1'b0) begin
        @(posedge CLK);
        c++;
      end
      if (c >= 999) begin
        bad("free run did not stop");
        conclude;
      end
      bus(1'b1, 4'h0, 32'h0);
      bus(1'b0, 4'h4, 32'h0);
      chk(rd, 1, "flag kept");
      bus(1'b1, 4'h4, 32'h1);
      q.delete();
    end
    conclude;
  end
endmodule
